// File: hdl/table_write_test_skip_xor_exec.sv
// executes one instruction word per cycle; the surrounding core supplies
// the file register contents in the word's own cycle, one cycle before file_addr_o shows the address
module table_write_test_skip_xor_exec
  import exec_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input fetch_t instr_i,
  input wire logic extended_set_enable_i,
  input wire logic [3:0] bank_select_reg_i,
  input wire logic [11:0] index_base_i,
  input wire logic [7:0] file_data_i,
  input wire logic [7:0] table_latch_i,
  input wire logic ptr_load_i,
  input wire logic [PTR_W-1:0] ptr_load_val_i,
  input wire logic [7:0] acc_load_i,
  input wire logic acc_load_en_i,
  output logic [PTR_W-1:0] table_pointer_o,
  output logic [HOLD_N*8-1:0] holding_o,
  output logic [7:0] acc_o,
  output logic flag_n_o,
  output logic flag_z_o,
  output logic [11:0] file_addr_o,
  output logic file_indexed_o,
  output logic busy_o,
  output logic flush_o
);
  // =====================================================================
  // decode
  logic is_table_write, is_xorl, is_tst;
  file_addr_t fa;
  logic [PTR_W-1:0] table_pointer_r;
  logic [7:0] hold_r [HOLD_N];
  logic [7:0] acc_r;
  logic flag_n_r, flag_z_r;
  logic [1:0] flush_cnt_r;
  logic skip_pending_r;

  // a flushed word is never decoded, so the new instruction only counts when idle
  wire logic live = instr_i.valid && (flush_cnt_r == 2'h0) && !skip_pending_r;
  assign is_table_write = live && instr_i.word[15:2] == TABLE_WRITE_HI;
  assign is_xorl = live && instr_i.word[15:8] == XORL_HI;
  assign is_tst = live && instr_i.word[15:9] == TEST_SKIP_HI;

  // the holding bank is indexed straight by the low pointer bits, so its size must match
  if (HOLD_N != (1 << HOLD_SEL_W) || PTR_W <= HOLD_SEL_W) begin : g_bad_cfg
    $error("holding bank size does not fit the pointer select width");
  end

  file_addr_gen u_addr (
    .f_i(instr_i.word[7:0]),
    .access_i(instr_i.word[8]),
    .bank_select_reg_i(bank_select_reg_i),
    .extended_set_enable_i(extended_set_enable_i),
    .index_base_i(index_base_i),
    .fa_o(fa)
  );

  // =====================================================================
  // table pointer and holding registers
  function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p, input logic up);
    ptr_step = up ? PTR_W'(p + 1'b1) : PTR_W'(p - 1'b1);
  endfunction : ptr_step

  wire logic [1:0] mode = instr_i.word[1:0];
  wire logic [PTR_W-1:0] eff_ptr = (mode == MODE_PRE_INC) ?
    ptr_step(table_pointer_r, 1'b1) : table_pointer_r;

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      table_pointer_r <= PTR_RST;
    end else if (ptr_load_i) begin
      table_pointer_r <= ptr_load_val_i;
    end else if (is_table_write) begin
      case (mode)
        MODE_KEEP: table_pointer_r <= table_pointer_r;
        MODE_POST_INC: table_pointer_r <= ptr_step(table_pointer_r, 1'b1);
        MODE_POST_DEC: table_pointer_r <= ptr_step(table_pointer_r, 1'b0);
        default: table_pointer_r <= eff_ptr;
      endcase
    end
  end

  // only the holding bank is written here; committing it to flash lies elsewhere
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < HOLD_N; i++) begin
        hold_r[i] <= BYTE_RST;
      end
    end else if (is_table_write) begin
      hold_r[eff_ptr[HOLD_SEL_W-1:0]] <= table_latch_i;
    end
  end

  // =====================================================================
  // accumulator and flags
  wire logic [7:0] xor_res = acc_r ^ instr_i.word[7:0];

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      acc_r <= BYTE_RST;
    end else if (is_xorl) begin
      acc_r <= xor_res;
    end else if (acc_load_en_i) begin
      acc_r <= acc_load_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      flag_n_r <= 1'b0;
      flag_z_r <= 1'b0;
    end else if (is_xorl) begin
      flag_n_r <= xor_res[7];
      flag_z_r <= (xor_res == 8'h00);
    end
  end

  // =====================================================================
  // test-skip flush control
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      skip_pending_r <= 1'b0;
    end else begin
      skip_pending_r <= is_tst && (file_data_i == 8'h00);
    end
  end

  // the cycle after a taken skip sees the prefetched word; its length sets the flush span
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      flush_cnt_r <= 2'h0;
    end else if (skip_pending_r) begin
      flush_cnt_r <= instr_i.two_word ? 2'h1 : 2'h0;
    end else if (flush_cnt_r != 2'h0) begin
      flush_cnt_r <= 2'(flush_cnt_r - 1'b1);
    end
  end

  // =====================================================================
  // registered outputs
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      file_addr_o <= 12'h000;
      file_indexed_o <= 1'b0;
      flush_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      file_addr_o <= fa.addr;
      file_indexed_o <= fa.indexed;
      flush_o <= skip_pending_r || (flush_cnt_r != 2'h0);
      // busy marks each cycle whose fetched word is about to be thrown away
      busy_o <= (is_tst && file_data_i == 8'h00) || skip_pending_r && instr_i.two_word;
    end
  end

  assign table_pointer_o = table_pointer_r;
  assign acc_o = acc_r;
  assign flag_n_o = flag_n_r;
  assign flag_z_o = flag_z_r;
  for (genvar g = 0; g < HOLD_N; g++) begin : g_hold
    assign holding_o[g*8 +: 8] = hold_r[g];
  end

  // =====================================================================
  // checks
  sequence taken_skip_s;
    is_tst && file_data_i == 8'h00;
  endsequence
  sequence long_skip_s;
    skip_pending_r && instr_i.two_word;
  endsequence

  skip_flush_one_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    taken_skip_s |=> ##1 flush_o) else $error("skipped word not flushed");
  skip_flush_two_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    long_skip_s |=> flush_o ##1 flush_o) else $error("second word not flushed");
  no_skip_nonzero_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    is_tst && file_data_i != 8'h00 |=> !skip_pending_r) else $error("skip on nonzero");
  post_inc_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    is_table_write && mode == MODE_POST_INC && !ptr_load_i |=>
    table_pointer_r == PTR_W'($past(table_pointer_r) + 1'b1)) else $error("post inc wrong");
  post_dec_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    is_table_write && mode == MODE_POST_DEC && !ptr_load_i |=>
    table_pointer_r == PTR_W'($past(table_pointer_r) - 1'b1)) else $error("post dec wrong");
  hold_write_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    is_table_write |=> hold_r[$past(eff_ptr[2:0])] == $past(table_latch_i))
    else $error("holding byte wrong");
  xor_result_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    is_xorl |=> acc_r == ($past(acc_r) ^ $past(instr_i.word[7:0])))
    else $error("xor result wrong");
  xor_flags_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    is_xorl |=> flag_z_r == (acc_r == 8'h00) && flag_n_r == acc_r[7])
    else $error("xor flags wrong");
  index_gate_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !extended_set_enable_i |=> !file_indexed_o) else $error("indexed with set off");

  // keep and pre-increment modes, slot taken from the stepped pointer
  keep_ptr_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    is_table_write && mode == MODE_KEEP && !ptr_load_i |=> $stable(table_pointer_r))
    else $error("pointer moved in keep mode");
  pre_inc_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    is_table_write && mode == MODE_PRE_INC && !ptr_load_i |=>
    table_pointer_r == PTR_W'($past(table_pointer_r) + 1'b1)) else $error("pre inc wrong");
  pre_inc_slot_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    is_table_write && mode == MODE_PRE_INC |=>
    hold_r[3'($past(table_pointer_r) + 1'b1)] == $past(table_latch_i))
    else $error("pre inc slot wrong");
  // only an xor literal may move the flags
  flags_kept_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !is_xorl |=> $stable(flag_n_r) && $stable(flag_z_r)) else $error("flags moved");
  busy_taken_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    taken_skip_s |=> busy_o) else $error("busy missing after skip");
  busy_long_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    long_skip_s |=> busy_o) else $error("busy missing on long skip");
  idle_no_flush_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !skip_pending_r && flush_cnt_r == 2'h0 |=> !flush_o) else $error("flush without skip");
  // a flushed word may not touch the accumulator or the pointer
  flush_acc_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (skip_pending_r || flush_cnt_r != 2'h0) && !acc_load_en_i |=> $stable(acc_r))
    else $error("flushed word changed accumulator");
  flush_ptr_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (skip_pending_r || flush_cnt_r != 2'h0) && !ptr_load_i |=> $stable(table_pointer_r))
    else $error("flushed word moved pointer");
endmodule : table_write_test_skip_xor_exec

// File: hdl/exec_pkg.sv
package exec_pkg;
  localparam int PTR_W = 21;
  localparam int HOLD_N = 8;
  localparam int HOLD_SEL_W = 3;
  localparam logic [13:0] TABLE_WRITE_HI = 14'h0003;
  localparam logic [7:0] XORL_HI = 8'h0A;
  localparam logic [6:0] TEST_SKIP_HI = 7'h33;
  localparam logic [7:0] INDEX_MAX = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [1:0] MODE_KEEP = 2'h0;
  localparam logic [1:0] MODE_POST_INC = 2'h1;
  localparam logic [1:0] MODE_POST_DEC = 2'h2;
  localparam logic [1:0] MODE_PRE_INC = 2'h3;
  localparam int FLAG_N = 4;
  localparam int FLAG_Z = 2;
  localparam logic [PTR_W-1:0] PTR_RST = 21'h00_0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef struct packed {
    logic [11:0] addr;
    logic indexed;
  } file_addr_t;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
    logic two_word;
  } fetch_t;
endpackage : exec_pkg

// File: hdl/file_addr_gen.sv
module file_addr_gen
  import exec_pkg::*;
(
  input wire logic [7:0] f_i,
  input wire logic access_i,
  input wire logic [3:0] bank_select_reg_i,
  input wire logic extended_set_enable_i,
  input wire logic [11:0] index_base_i,
  output file_addr_t fa_o
);
  always_comb begin
    fa_o.indexed = 1'b0;
    if (access_i) begin
      fa_o.addr = {bank_select_reg_i, f_i};
    end else if (extended_set_enable_i && f_i <= INDEX_MAX) begin
      fa_o.indexed = 1'b1;
      fa_o.addr = 12'(index_base_i + {4'h0, f_i});
    end else if (f_i < ACCESS_SPLIT) begin
      fa_o.addr = {4'h0, f_i};
    end else begin
      fa_o.addr = {ACCESS_HI_BANK, f_i};
    end
  end
endmodule : file_addr_gen

// File: testbench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  `define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
  // ==========================================================
  // stimulus and design
  logic clock_i = 0, resetn_i = 0, ext_en = 0, ptr_ld = 0, acc_en = 0;
  fetch_t instr_i = '0;
  logic [3:0] bank_select_reg = 4'h0;
  logic [11:0] base = 12'h000;
  logic [7:0] fdata = 8'h01, latch = 8'h00, acc_ld = 8'h00, acc_o;
  logic [PTR_W-1:0] ptr_val = '0, ptr_o;
  logic [HOLD_N*8-1:0] hold_o;
  logic [11:0] fa_o;
  logic fn_o, fz_o, fi_o, busy_o, flush_o;
  int n_errors = 0, n_tests = 0;
  initial forever #5 clock_i = ~clock_i;
  table_write_test_skip_xor_exec u_dut (.clock_i(clock_i), .resetn_i(resetn_i),
    .instr_i(instr_i), .extended_set_enable_i(ext_en), .bank_select_reg_i(bank_select_reg),
    .index_base_i(base), .file_data_i(fdata), .table_latch_i(latch),
    .ptr_load_i(ptr_ld), .ptr_load_val_i(ptr_val), .acc_load_i(acc_ld),
    .acc_load_en_i(acc_en), .table_pointer_o(ptr_o), .holding_o(hold_o), .acc_o(acc_o),
    .flag_n_o(fn_o), .flag_z_o(fz_o), .file_addr_o(fa_o), .file_indexed_o(fi_o),
    .busy_o(busy_o), .flush_o(flush_o));
  // ==========================================================
  // helpers
  task step; @(posedge clock_i); #1; endtask : step
  // an idle edge after each word keeps valid from falling and rising in one time step
  task issue(input logic [15:0] w);
    instr_i = '{1'b1, w, 1'b0};
    step;
    instr_i.valid = 1'b0;
    step;
  endtask : issue
  function automatic logic [15:0] tst(input logic a, input logic [7:0] f);
    return {8'h66 | {7'h00, a}, f};
  endfunction : tst
  // ==========================================================
  // scenarios
  task automatic tw_modes;
    logic [PTR_W-1:0] sp [4] = '{21'h00_A356, 21'h1F_FFFF, 21'h00_0000, 21'h1F_FFFF};
    logic [PTR_W-1:0] ep [4] = '{21'h00_A356, 21'h00_0000, 21'h1F_FFFF, 21'h00_0000};
    int slot [4] = '{6, 7, 0, 0};
    for (int m = 0; m < 4; m++) begin
      ptr_val = sp[m]; ptr_ld = 1'b1; step; ptr_ld = 1'b0;
      latch = 8'h50 + 8'(m);
      issue(16'h000C | 16'(m));
      `CHK(ptr_o, ep[m])
      `CHK(hold_o[8*slot[m] +: 8], latch)
    end
    $display("test table write modes done");
  endtask : tw_modes
  task xor_case(input logic [7:0] k, input logic [7:0] r);
    issue({XORL_HI, k});
    `CHK(acc_o, r)
    `CHK({fn_o, fz_o}, {r[7], r == 8'h00})
  endtask : xor_case
  task skip_case(input logic z, input logic tw);
    int n;
    int b;
    n = 0;
    b = 0;
    acc_ld = 8'h3C; acc_en = 1'b1; step; acc_en = 1'b0;
    fdata = z ? 8'h00 : 8'h01;
    instr_i = '{1'b1, tst(1'b0, 8'h10), 1'b0};
    step;
    `CHK(busy_o, z)
    instr_i = '{1'b1, 16'h0AFF, tw};
    step;
    `CHK(flush_o, z)
    n += int'(flush_o);
    b += int'(busy_o);
    instr_i = '{1'b1, 16'h0AFF, 1'b0};
    step;
    `CHK(flush_o, z && tw)
    n += int'(flush_o);
    b += int'(busy_o);
    instr_i.valid = 1'b0;
    repeat (3) begin
      step;
      n += int'(flush_o);
      b += int'(busy_o);
    end
    fdata = 8'h01;
    `CHK(n, z ? (tw ? 2 : 1) : 0)
    `CHK(b, (z && tw) ? 1 : 0)
    `CHK(acc_o, (z && !tw) ? 8'hC3 : 8'h3C)
    $display("test skip z=%0d two_word=%0d done", z, tw);
  endtask : skip_case
  task addr_case(input logic e, a, input logic [7:0] f, input logic [11:0] ea, input logic ei);
    ext_en = e;
    issue(tst(a, f));
    `CHK({fa_o, fi_o}, {ea, ei})
  endtask : addr_case
  // ==========================================================
  // verdict and sequence
  task complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  initial begin #200000; n_errors++; complete_run; end
  initial begin
    repeat (2) step;
    resetn_i = 1'b1;
    `CHK({ptr_o, hold_o, acc_o, fn_o, fz_o, flush_o, busy_o, fa_o, fi_o}, '0)
    tw_modes;
    xor_case(8'hB5, 8'hB5);
    xor_case(8'h35, 8'h80);
    xor_case(8'h80, 8'h00);
    $display("test xor literal done");
    skip_case(1'b1, 1'b0);
    skip_case(1'b1, 1'b1);
    skip_case(1'b0, 1'b0);
    bank_select_reg = 4'h3; base = 12'h100;
    addr_case(1'b0, 1'b0, 8'h10, 12'h010, 1'b0);
    addr_case(1'b0, 1'b0, 8'h80, 12'hF80, 1'b0);
    addr_case(1'b1, 1'b1, 8'h20, 12'h320, 1'b0);
    addr_case(1'b1, 1'b0, 8'h5F, 12'h15F, 1'b1);
    addr_case(1'b1, 1'b0, 8'h60, 12'hF60, 1'b0);
    $display("test addressing done");
    complete_run;
  end
endmodule : tb
